// [src/roi_regs_pkg.sv]
package roi_regs_pkg;

	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam logic [47:0] F7_BASE = 48'hffff_f1f0_0000;
	localparam logic [11:0] OFS_MAX_EXTENT = 12'h000;
	localparam logic [11:0] OFS_STEP_SIZE = 12'h004;
	localparam logic [11:0] OFS_ORIGIN = 12'h008;
	localparam logic [11:0] OFS_EXTENT = 12'h00c;
	localparam logic [11:0] OFS_FMT_SELECT = 12'h010;
	localparam logic [11:0] OFS_FMT_SUPPORT = 12'h014;
	localparam logic [11:0] OFS_ERR_HIGH = 12'h640;
	localparam logic [11:0] OFS_ERR_LOW = 12'h644;

	// ----------------------------------------
	// field layout, bit 0 is the msb of the word
	// ----------------------------------------
	localparam int WORD_MSB = 31;
	localparam int DOC_TRIG_ERR_BIT = 12;
	localparam int TRIG_ERR_POS = WORD_MSB - DOC_TRIG_ERR_BIT;

	// ----------------------------------------
	// inquiry values and reset values
	// ----------------------------------------
	localparam logic [15:0] MAX_H = 16'h0500;
	localparam logic [15:0] MAX_V = 16'h0400;
	localparam logic [15:0] STEP_H = 16'h0004;
	localparam logic [15:0] STEP_V = 16'h0001;
	localparam logic [31:0] ORIGIN_RST = 32'h0000_0000;
	localparam logic [31:0] EXTENT_RST = {MAX_H, MAX_V};
	localparam logic [7:0] FMT_RST = 8'h00;
	localparam logic [7:0] FMT_MONO8 = 8'h00;
	localparam logic [7:0] FMT_MONO16 = 8'h05;
	localparam logic [31:0] FMT_SUPPORT = (32'h8000_0000 >> FMT_MONO8)
		| (32'h8000_0000 >> FMT_MONO16);

	// ----------------------------------------
	// trigger setting limits
	// ----------------------------------------
	localparam logic [3:0] TRIG_MODE_MAX_EXT = 4'h1;
	localparam logic [3:0] TRIG_MODE_MAX_SOFT = 4'h0;
	localparam logic [2:0] TRIG_SRC_MAX_PIN = 3'h3;
	localparam logic [2:0] TRIG_SRC_SOFT = 3'h7;

endpackage

// [src/trig_range_check.sv]
`timescale 1ns/10ps
module trig_range_check
	import roi_regs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_wr,
	input wire logic [3:0] i_mode,
	input wire logic [2:0] i_source,
	output logic o_err
);

	logic err_ff;
	logic nxt_err;
	wire logic soft_src = (i_source == TRIG_SRC_SOFT);
	wire logic src_bad = (i_source > TRIG_SRC_MAX_PIN) && !soft_src;
	wire logic mode_bad = soft_src ? (i_mode > TRIG_MODE_MAX_SOFT)
		: (i_mode > TRIG_MODE_MAX_EXT);
	wire logic setting_bad = src_bad || mode_bad;

	// only a write refreshes the flag; capture goes on regardless
	assign nxt_err = i_wr ? setting_bad : err_ff;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			err_ff <= 1'b0;
		end else begin
			err_ff <= nxt_err;
		end
	end

	assign o_err = err_ff;

	trig_refresh_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		i_wr |=> o_err == $past(setting_bad))
		else $error("trigger error flag not refreshed on write");
	trig_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!i_wr |=> $stable(o_err))
		else $error("trigger error flag changed without write");
	soft_mode_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_wr && i_source == TRIG_SRC_SOFT && i_mode == 4'h1) |=> o_err)
		else $error("software trigger in level mode not flagged");

endmodule // trig_range_check

// [src/roi_format_and_error_regs.sv]
`timescale 1ns/10ps
module roi_format_and_error_regs
	import roi_regs_pkg::*;
#(
	// base of the feature control space; default value is arbitrary
	parameter logic [47:0] FEAT_BASE = 48'hffff_f000_0000
)(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [47:0] i_req_addr,
	input wire logic [31:0] i_req_wdata,
	output logic o_resp_valid,
	output logic [31:0] o_resp_rdata,
	output logic o_resp_err,
	input wire logic i_trig_ctrl_wr,
	input wire logic [3:0] i_trig_mode,
	input wire logic [2:0] i_trig_source,
	output logic o_trig_err,
	output logic [15:0] o_roi_left,
	output logic [15:0] o_roi_top,
	output logic [15:0] o_roi_width,
	output logic [15:0] o_roi_height,
	output logic [7:0] o_pixel_format_code
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire logic [11:0] ofs = i_req_addr[11:0];
	wire logic f7_hit = (i_req_addr[47:12] == F7_BASE[47:12]);
	wire logic feat_hit = (i_req_addr[47:12] == FEAT_BASE[47:12]);
	wire logic sel_max = f7_hit && (ofs == OFS_MAX_EXTENT);
	wire logic sel_step = f7_hit && (ofs == OFS_STEP_SIZE);
	wire logic sel_origin = f7_hit && (ofs == OFS_ORIGIN);
	wire logic sel_extent = f7_hit && (ofs == OFS_EXTENT);
	wire logic sel_fmt = f7_hit && (ofs == OFS_FMT_SELECT);
	wire logic sel_support = f7_hit && (ofs == OFS_FMT_SUPPORT);
	wire logic sel_err_hi = feat_hit && (ofs == OFS_ERR_HIGH);
	wire logic sel_err_lo = feat_hit && (ofs == OFS_ERR_LOW);
	// anything else, misaligned offsets too, answers with the error flag
	wire logic mapped = sel_max || sel_step || sel_origin || sel_extent
		|| sel_fmt || sel_support || sel_err_hi || sel_err_lo;
	wire logic wr_go = i_req_valid && i_req_write;

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	logic [31:0] origin_ff;
	logic [31:0] extent_ff;
	logic [7:0] fmt_ff;
	logic [31:0] nxt_origin;
	logic [31:0] nxt_extent;
	logic [7:0] nxt_fmt;
	logic trig_err;

	// code is stored even if unsupported; picking a valid one is up to the host
	assign nxt_origin = (wr_go && sel_origin) ? i_req_wdata : origin_ff;
	assign nxt_extent = (wr_go && sel_extent) ? i_req_wdata : extent_ff;
	assign nxt_fmt = (wr_go && sel_fmt) ? i_req_wdata[31:24] : fmt_ff;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			origin_ff <= ORIGIN_RST;
			extent_ff <= EXTENT_RST;
			fmt_ff <= FMT_RST;
		end else begin
			origin_ff <= nxt_origin;
			extent_ff <= nxt_extent;
			fmt_ff <= nxt_fmt;
		end
	end

	trig_range_check u_trig (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_wr(i_trig_ctrl_wr),
		.i_mode(i_trig_mode),
		.i_source(i_trig_source),
		.o_err(trig_err)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire logic [31:0] err_hi_word = {{(31 - TRIG_ERR_POS){1'b0}}, trig_err,
		{TRIG_ERR_POS{1'b0}}};
	wire logic [31:0] fmt_word = {fmt_ff, 24'h00_0000};
	wire logic [31:0] rd_word =
		sel_max ? {MAX_H, MAX_V} :
		sel_step ? {STEP_H, STEP_V} :
		sel_origin ? origin_ff :
		sel_extent ? extent_ff :
		sel_fmt ? fmt_word :
		sel_support ? FMT_SUPPORT :
		sel_err_hi ? err_hi_word :
		32'h0000_0000;

	logic resp_valid_ff;
	logic [31:0] resp_rdata_ff;
	logic resp_err_ff;
	logic [31:0] nxt_rdata;

	// writes to read-only words are acked and dropped
	assign nxt_rdata = (i_req_valid && !i_req_write) ? rd_word : 32'h0000_0000;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			resp_valid_ff <= 1'b0;
			resp_rdata_ff <= 32'h0000_0000;
			resp_err_ff <= 1'b0;
		end else begin
			resp_valid_ff <= i_req_valid;
			resp_rdata_ff <= nxt_rdata;
			resp_err_ff <= i_req_valid && !mapped;
		end
	end

	assign o_resp_valid = resp_valid_ff;
	assign o_resp_rdata = resp_rdata_ff;
	assign o_resp_err = resp_err_ff;
	assign o_trig_err = trig_err;
	assign o_roi_left = origin_ff[31:16];
	assign o_roi_top = origin_ff[15:0];
	assign o_roi_width = extent_ff[31:16];
	assign o_roi_height = extent_ff[15:0];
	assign o_pixel_format_code = fmt_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	wire logic rd_go = i_req_valid && !i_req_write;

	resp_timing_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		i_req_valid |=> o_resp_valid ##1 !o_resp_valid || $past(i_req_valid))
		else $error("response not one cycle after request");
	unmapped_err_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_req_valid && !f7_hit && !feat_hit) |=> o_resp_err && o_resp_rdata == 32'h0)
		else $error("unmapped access not refused");
	max_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && i_req_addr == F7_BASE) |=> o_resp_rdata == 32'h0500_0400)
		else $error("max size inquiry wrong");
	step_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && sel_step) |=> o_resp_rdata == 32'h0004_0001 && !o_resp_err)
		else $error("step inquiry wrong");
	origin_store_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_go && sel_origin) |=> o_roi_left == $past(i_req_wdata[31:16])
		&& o_roi_top == $past(i_req_wdata[15:0]))
		else $error("origin write not stored");
	extent_store_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_go && sel_extent) ##1 (rd_go && sel_extent)
		|=> o_resp_rdata == $past(i_req_wdata, 2))
		else $error("extent readback mismatch");
	fmt_reserved_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && sel_fmt) |=> o_resp_rdata[23:0] == 24'h0
		&& o_resp_rdata[31:24] == o_pixel_format_code)
		else $error("format select readback wrong");
	support_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && sel_support) |=> o_resp_rdata == 32'h8400_0000)
		else $error("format support word wrong");
	err_low_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_req_valid && sel_err_lo) |=> o_resp_rdata == 32'h0 && !o_resp_err)
		else $error("low error word not zero");
	err_high_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && sel_err_hi) |=> o_resp_rdata == {12'h0, $past(trig_err), 19'h0})
		else $error("trigger error bit misplaced");
	extent_gap_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_go && sel_extent) ##1 !(wr_go && sel_extent) ##1 (rd_go && sel_extent)
		|=> o_resp_rdata == $past(i_req_wdata, 3))
		else $error("extent readback after gap mismatch");
	fmt_store_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_go && sel_fmt) |=> o_pixel_format_code == $past(i_req_wdata[31:24]))
		else $error("format code not taken from top byte");
	err_hi_reserved_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && sel_err_hi) |=> (o_resp_rdata & ~32'h0008_0000) == 32'h0)
		else $error("unused high error bits not zero");
	err_with_valid_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_resp_err |-> o_resp_valid)
		else $error("error flag without response");
	support_bits_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_go && sel_support) |=> o_resp_rdata[WORD_MSB - int'(FMT_MONO8)]
		&& o_resp_rdata[WORD_MSB - int'(FMT_MONO16)])
		else $error("support bit not at code position");
	origin_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!(wr_go && sel_origin) |=> $stable({o_roi_left, o_roi_top}))
		else $error("origin changed without write");
	ro_write_ok_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_go && (sel_max || sel_step || sel_support || sel_err_hi || sel_err_lo))
		|=> o_resp_valid && !o_resp_err && o_resp_rdata == 32'h0)
		else $error("read-only write not acked cleanly");

	// ----------------------------------------
	// coverage
	// ----------------------------------------
	origin_wr_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_go && sel_origin ##1 rd_go && sel_origin);
	trig_err_rd_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		rd_go && sel_err_hi && trig_err);
	unmapped_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		i_req_valid && !mapped);
	fmt_wr_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_go && sel_fmt);
	ro_wr_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_go && sel_support);

endmodule // roi_format_and_error_regs

// [test/host_model.sv]
`timescale 1ns/10ps
module host_model (
	input wire logic i_clk,
	output logic o_req_valid,
	output logic o_req_write,
	output logic [47:0] o_req_addr,
	output logic [31:0] o_req_wdata,
	input wire logic i_resp_valid,
	input wire logic [31:0] i_resp_rdata,
	input wire logic i_resp_err
);
	initial begin
		o_req_valid = 1'b0;
		o_req_write = 1'b0;
		o_req_addr = 48'h0;
		o_req_wdata = 32'h0;
	end
	// one quadlet per request, held until the taking edge
	task automatic xfer(input logic w, input logic [47:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er, output logic ok);
		@(negedge i_clk);
		o_req_valid = 1'b1;
		o_req_write = w;
		o_req_addr = a;
		o_req_wdata = d;
		@(negedge i_clk);
		o_req_valid = 1'b0;
		// released lines must not look valid
		o_req_addr = ~a;
		o_req_wdata = ~d;
		q = i_resp_rdata;
		er = i_resp_err;
		ok = i_resp_valid;
	endtask
endmodule // host_model

// [test/roi_format_and_error_regs_tb_top.sv]
`timescale 1ns/10ps
module roi_format_and_error_regs_tb_top;
	import roi_regs_pkg::*;
	localparam logic [47:0] FEAT = 48'hffff_f000_0000;
	logic clk, arst_n, valid, wr, rv, re, tw, terr;
	logic [47:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] tm;
	logic [2:0] ts;
	logic [15:0] left, top, width, height;
	logic [7:0] fmt;
	int n_fail, checks, cyc;
	roi_format_and_error_regs #(.FEAT_BASE(FEAT)) i_roi_format_and_error_regs (
		.i_clk(clk), .i_arst_n(arst_n), .i_req_valid(valid), .i_req_write(wr),
		.i_req_addr(addr), .i_req_wdata(wdata), .o_resp_valid(rv), .o_resp_rdata(rdata),
		.o_resp_err(re), .i_trig_ctrl_wr(tw), .i_trig_mode(tm), .i_trig_source(ts),
		.o_trig_err(terr), .o_roi_left(left), .o_roi_top(top), .o_roi_width(width),
		.o_roi_height(height), .o_pixel_format_code(fmt));
	host_model i_host_model (.i_clk(clk), .o_req_valid(valid), .o_req_write(wr),
		.o_req_addr(addr), .o_req_wdata(wdata), .i_resp_valid(rv), .i_resp_rdata(rdata),
		.i_resp_err(re));
	task automatic summarize();
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic x);
		cmp_word({31'h0, g}, {31'h0, x});
	endtask
	task automatic acc(input logic w, input logic [47:0] a, input logic [31:0] d,
		input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic er, ok;
		i_host_model.xfer(w, a, d, q, er, ok);
		cmp_bit(ok, 1'b1);
		cmp_bit(er, xe);
		cmp_word(q, x);
	endtask
	function automatic logic [47:0] f7(input logic [11:0] o);
		return F7_BASE + {36'h0, o};
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		cmp_word({left, top}, 32'h0);
		cmp_word({width, height}, 32'h0500_0400);
		cmp_word({24'h0, fmt}, 32'h0);
		cmp_bit(terr, 1'b0);
		acc(1'b0, f7(12'h000), 32'h0, 32'h0500_0400, 1'b0);
		acc(1'b0, f7(12'h004), 32'h0, 32'h0004_0001, 1'b0);
		acc(1'b0, f7(12'h008), 32'h0, 32'h0, 1'b0);
		acc(1'b0, f7(12'h00c), 32'h0, 32'h0500_0400, 1'b0);
		acc(1'b0, f7(12'h010), 32'h0, 32'h0, 1'b0);
		acc(1'b0, f7(12'h014), 32'h0, 32'h8400_0000, 1'b0);
		acc(1'b0, FEAT + 48'h640, 32'h0, 32'h0, 1'b0);
		acc(1'b0, FEAT + 48'h644, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic t_rw();
		acc(1'b1, f7(12'h008), 32'h0010_0020, 32'h0, 1'b0);
		cmp_word({left, top}, 32'h0010_0020);
		acc(1'b1, f7(12'h00c), 32'h0100_0080, 32'h0, 1'b0);
		cmp_word({width, height}, 32'h0100_0080);
		acc(1'b0, f7(12'h00c), 32'h0, 32'h0100_0080, 1'b0);
		acc(1'b1, f7(12'h010), 32'h05ff_ffff, 32'h0, 1'b0);
		cmp_word({24'h0, fmt}, 32'h05);
		acc(1'b0, f7(12'h010), 32'h0, 32'h0500_0000, 1'b0);
		acc(1'b0, f7(12'h008), 32'h0, 32'h0010_0020, 1'b0);
		acc(1'b0, f7(12'h00c), 32'h0, 32'h0100_0080, 1'b0);
	endtask
	task automatic t_ro();
		acc(1'b1, f7(12'h000), 32'hffff_ffff, 32'h0, 1'b0);
		acc(1'b1, f7(12'h014), 32'hffff_ffff, 32'h0, 1'b0);
		acc(1'b1, FEAT + 48'h644, 32'hffff_ffff, 32'h0, 1'b0);
		acc(1'b0, f7(12'h000), 32'h0, 32'h0500_0400, 1'b0);
		acc(1'b0, f7(12'h014), 32'h0, 32'h8400_0000, 1'b0);
		acc(1'b0, FEAT + 48'h644, 32'h0, 32'h0, 1'b0);
		acc(1'b0, f7(12'h018), 32'h0, 32'h0, 1'b1);
		acc(1'b1, f7(12'h018), 32'hffff_ffff, 32'h0, 1'b1);
		acc(1'b0, f7(12'h002), 32'h0, 32'h0, 1'b1);
		acc(1'b0, 48'h0000_f1f0_0000, 32'h0, 32'h0, 1'b1);
	endtask
	// out of range: source 4..6, pin mode above 1, software mode above 0
	task automatic t_trig();
		logic bad;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			tw = 1'b1;
			tm = (i % 4 == 3) ? 4'hf : 4'(i % 4);
			ts = 3'(i / 4);
			bad = (ts inside {[3'h4:3'h6]}) || (ts == 3'h7 ? tm != 4'h0 : tm > 4'h1);
			@(negedge clk);
			tw = 1'b0;
			tm = ~tm;
			cmp_bit(terr, bad);
			acc(1'b1, FEAT + 48'h640, 32'hffff_ffff, 32'h0, 1'b0);
			acc(1'b0, FEAT + 48'h640, 32'h0, {12'h0, bad, 19'h0}, 1'b0);
			cmp_word({width, height}, 32'h0100_0080);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		arst_n = 1'b0;
		tw = 1'b0;
		tm = 4'h0;
		ts = 3'h0;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		t_reset();
		t_rw();
		t_ro();
		t_trig();
		@(negedge clk);
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		t_reset();
		summarize();
	end
endmodule // roi_format_and_error_regs_tb_top
